// file: bench/soo_host.sv
// host-side register bus master model for the status block
`timescale 1ns/1ps
`default_nettype none
module soo_host
  import soo_pkg::*;
(
  input  wire logic          clk,
  input  wire logic [DW-1:0] rdata,
  output logic      [AW-1:0] addr,
  output logic      [DW-1:0] wdata,
  output logic               wr,
  output logic               rd
);
  initial begin
    addr  = '0;
    wdata = '0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus cycles: one-cycle strobes launched after a rising edge
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] dt);
    @(posedge clk);
    addr  <= a;
    wdata <= dt;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] dt);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    dt = rdata;
  endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the status and output-off block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin num_errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module tb
  import soo_pkg::*;
;
  localparam int DISP = 30;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, d;
  logic [DW-1:0] las_cond = '0, las_evt = '0, tec_cond = '0, tec_evt = '0;
  logic [7:1] esr_evt = '0;
  logic wr, rd, srq, stall, las_off, tec_off, las_act, tec_act, las_req, tec_req;
  logic [7:0] las_code, tec_code;
  logic outq = 0, cmd = 0, opc = 0, wai = 0, las_upd = 0, tec_upd = 0, nv = 0, cal = 0;
  logic las_on = 0, las_tol = 0, tec_on = 0, tec_tol = 0, push = 0, chan = 0;
  logic [7:0] code = '0;
  int num_errors = 0;
  int n_checks = 0;

  soo_status #(.LAS_MEAS_CYCLES(20), .TEC_MEAS_CYCLES(12), .DISP_CYCLES(DISP)) soo_status_inst (
    .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .LAS_COND(las_cond), .LAS_EVT(las_evt), .TEC_COND(tec_cond), .TEC_EVT(tec_evt),
    .ESR_EVT(esr_evt), .OUTQ_NOT_EMPTY(outq), .CMD_PARSED(cmd), .OPC_CMD(opc),
    .WAI_CMD(wai), .LAS_UPD_BUSY(las_upd), .TEC_UPD_BUSY(tec_upd), .NV_WRITE_BUSY(nv),
    .CAL_RUN(cal), .LAS_OUT_ON(las_on), .LAS_IN_TOL(las_tol), .TEC_OUT_ON(tec_on),
    .TEC_IN_TOL(tec_tol), .ERR_PUSH(push), .ERR_CODE(code), .ERR_CHAN(chan), .SRQ(srq),
    .STALL(stall), .LAS_OUT_OFF(las_off), .TEC_OUT_OFF(tec_off), .LAS_MEAS_REQ(las_req),
    .TEC_MEAS_REQ(tec_req), .LAS_DISP_ACTIVE(las_act), .LAS_DISP_CODE(las_code),
    .TEC_DISP_ACTIVE(tec_act), .TEC_DISP_CODE(tec_code));
  soo_host soo_host_inst (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd));

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // bounded wait on srq (sel 0) or stall (sel 1)
  task wait_for(input int sel, input logic val, input string nm);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? srq : stall) === val) break;
    end
    `CHK(nm, val, (sel == 0 ? srq : stall));
  endtask

  task set_blk(input int k, input logic v);
    case (k)
      0: las_upd <= v;
      1: tec_upd <= v;
      2: nv <= v;
      3: cal <= v;
      4: begin las_on <= 1'b1; las_tol <= !v; end
      default: begin tec_on <= 1'b1; tec_tol <= !v; end
    endcase
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    soo_host_inst.wr_reg(5'h1F, 16'hFFFF);
    soo_host_inst.rd_reg(5'h1F, d);
    `CHK("unmapped", 16'h0000, d);
    soo_host_inst.rd_reg(A_LAS_OFF, d);
    `CHK("las_off_mask", 16'h0888, d);
    soo_host_inst.rd_reg(A_TEC_OFF, d);
    `CHK("tec_off_mask", 16'h05E8, d);
  endtask

  task t_evt;
    @(posedge clk);
    las_evt <= 16'h0008;
    las_cond <= 16'h0002;
    @(posedge clk);
    las_evt <= '0;
    repeat (3) @(posedge clk);
    soo_host_inst.rd_reg(A_LAS_EVT, d);
    `CHK("las_evt", 16'h0008, d);
    soo_host_inst.rd_reg(A_LAS_EVT, d);
    `CHK("las_evt_clr", 16'h0000, d);
    soo_host_inst.rd_reg(A_LAS_COND, d);
    soo_host_inst.rd_reg(A_LAS_COND, d);
    `CHK("las_cond", 16'h0002, d);
    fork
      soo_host_inst.rd_reg(A_TEC_EVT, d);
      begin @(posedge clk); tec_evt <= 16'h0020; @(posedge clk); tec_evt <= '0; end
    join
    `CHK("tec_off_evt", 1'b1, tec_off);
    soo_host_inst.rd_reg(A_TEC_EVT, d);
    `CHK("tec_evt_kept", 16'h0020, d);
    `CHK("tec_off_clr", 1'b0, tec_off);
  endtask

  task t_sum;
    soo_host_inst.wr_reg(A_LAS_EN_C, 16'h0001);
    soo_host_inst.rd_reg(A_STB, d);
    `CHK("stb_masked", 16'h0000, d & 16'h0001);
    @(posedge clk);
    las_cond <= 16'h0009;
    soo_host_inst.wr_reg(A_SRE, 16'h0001);
    #1 `CHK("srq_sum", 1'b1, srq);
    soo_host_inst.rd_reg(A_STB, d);
    `CHK("stb_mss", 16'h0041, d & 16'h0041);
    `CHK("las_off_cond", 1'b1, las_off);
    soo_host_inst.wr_reg(A_LAS_OFF, 16'h0000);
    #1 `CHK("las_off_mask0", 1'b0, las_off);
    soo_host_inst.wr_reg(A_SRE, 16'h0000);
    soo_host_inst.wr_reg(A_LAS_EN_C, 16'h0000);
  endtask

  task t_opc(input int k);
    soo_host_inst.wr_reg(A_ESE, 16'h0001);
    soo_host_inst.wr_reg(A_SRE, 16'h0020);
    set_blk(k, 1'b1);
    cmd <= 1'b1;
    opc <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
    opc <= 1'b0;
    repeat (50) @(posedge clk);
    #1 `CHK("srq_blocked", 1'b0, srq);
    @(posedge clk);
    set_blk(k, 1'b0);
    wait_for(0, 1'b1, "srq_done");
    soo_host_inst.rd_reg(A_ESR, d);
    `CHK("esr_opc", 16'h0001, d);
    soo_host_inst.rd_reg(A_ESR, d);
    `CHK("esr_clr", 16'h0000, d);
  endtask

  task t_wai;
    @(posedge clk);
    las_upd <= 1'b1;
    wai <= 1'b1;
    #1 `CHK("stall_on", 1'b1, stall);
    @(posedge clk);
    wai <= 1'b0;
    repeat (5) @(posedge clk);
    #1 `CHK("stall_hold", 1'b1, stall);
    @(posedge clk);
    las_upd <= 1'b0;
    wait_for(1, 1'b0, "stall_off");
  endtask

  task t_errq;
    int i;
    outq <= 1'b1;
    for (i = 1; i <= 12; i++) begin
      @(posedge clk);
      push <= 1'b1;
      code <= 8'(i);
    end
    @(posedge clk);
    push <= 1'b0;
    soo_host_inst.rd_reg(A_STB, d);
    `CHK("stb_q", 16'h0090, d & 16'h0090);
    `CHK("las_disp_code", 8'h0C, las_code);
    soo_host_inst.rd_reg(A_ERR_COUNT, d);
    `CHK("err_count", 16'h000C, d);
    soo_host_inst.wr_reg(A_ERR_START, 16'h0000);
    for (i = 1; i <= 11; i++) begin
      soo_host_inst.rd_reg(A_ERR_DATA, d);
      `CHK("err_data", (i <= 10 ? 16'(i) : 16'h0000), d);
    end
    soo_host_inst.wr_reg(A_ERR_START, 16'h0000);
    soo_host_inst.rd_reg(A_ERR_DATA, d);
    soo_host_inst.rd_reg(A_ERR_DATA, d);
    `CHK("err_last", 16'h000C, d);
    outq <= 1'b0;
    soo_host_inst.rd_reg(A_STB, d);
    `CHK("stb_q_empty", 16'h0000, d & 16'h0090);
  endtask

  task t_disp;
    repeat (DISP + 10) @(posedge clk);
    push <= 1'b1;
    chan <= 1'b1;
    code <= 8'h55;
    @(posedge clk);
    push <= 1'b0;
    #1 `CHK("tec_disp", 9'h155, {tec_act, tec_code});
    `CHK("las_disp", 1'b0, las_act);
    repeat (10) @(posedge clk);
    push <= 1'b1;
    code <= 8'h66;
    @(posedge clk);
    push <= 1'b0;
    #1 `CHK("disp_replace", 8'h66, tec_code);
    repeat (DISP - 3) @(posedge clk);
    #1 `CHK("disp_held", 1'b1, tec_act);
    repeat (4) @(posedge clk);
    #1 `CHK("disp_gone", 1'b0, tec_act);
  endtask

  // refresh pulses over one common period, then temp condition and standard event
  task t_meas;
    int nl;
    int nt;
    nl = 0;
    nt = 0;
    repeat (60) begin
      @(posedge clk);
      #1;
      nl += las_req;
      nt += tec_req;
    end
    `CHK("las_meas_req", 3, nl);
    `CHK("tec_meas_req", 5, nt);
    tec_cond <= 16'h0008;
    esr_evt  <= 7'h40;
    @(posedge clk);
    esr_evt  <= 7'h00;
    #1 `CHK("tec_off_cond", 1'b1, tec_off);
    soo_host_inst.rd_reg(A_ESR, d);
    `CHK("esr_evt", 16'h0080, d);
    tec_cond <= 16'h0000;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_evt;
    t_sum;
    for (int k = 0; k < 6; k++) begin
      t_opc(k);
    end
    t_wai;
    t_errq;
    t_disp;
    t_meas;
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire

// file: hdl/soo_pkg.sv
// package: register map, field positions, reset values and timing for status/output-off logic
package soo_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DW         = 16;
  localparam int AW         = 5;
  localparam int ERRQ_DEPTH = 16;
  localparam int ERR_RESP_MAX = 10;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] A_STB       = 5'h00;
  localparam logic [AW-1:0] A_SRE       = 5'h01;
  localparam logic [AW-1:0] A_ESR       = 5'h02;
  localparam logic [AW-1:0] A_ESE       = 5'h03;
  localparam logic [AW-1:0] A_LAS_COND  = 5'h04;
  localparam logic [AW-1:0] A_LAS_EVT   = 5'h05;
  localparam logic [AW-1:0] A_LAS_EN_C  = 5'h06;
  localparam logic [AW-1:0] A_LAS_EN_E  = 5'h07;
  localparam logic [AW-1:0] A_TEC_COND  = 5'h08;
  localparam logic [AW-1:0] A_TEC_EVT   = 5'h09;
  localparam logic [AW-1:0] A_TEC_EN_C  = 5'h0A;
  localparam logic [AW-1:0] A_TEC_EN_E  = 5'h0B;
  localparam logic [AW-1:0] A_LAS_OFF   = 5'h0C;
  localparam logic [AW-1:0] A_TEC_OFF   = 5'h0D;
  localparam logic [AW-1:0] A_ERR_DATA  = 5'h10;
  localparam logic [AW-1:0] A_ERR_COUNT = 5'h11;
  localparam logic [AW-1:0] A_ERR_START = 5'h12;

  // ----------------------------------------------------------------
  // status byte bit positions
  // ----------------------------------------------------------------
  localparam int STB_LAS_C = 0;
  localparam int STB_LAS_E = 1;
  localparam int STB_TEC_C = 2;
  localparam int STB_TEC_E = 3;
  localparam int STB_OUTQ  = 4;
  localparam int STB_ESR   = 5;
  localparam int STB_MSS   = 6;
  localparam int STB_ERRQ  = 7;
  localparam int ESR_OPC   = 0;

  // ----------------------------------------------------------------
  // reset values (output-off masks keep factory defaults)
  // ----------------------------------------------------------------
  localparam logic [DW-1:0] LAS_OFF_DEFAULT = 16'h0888;
  localparam logic [DW-1:0] TEC_OFF_DEFAULT = 16'h05E8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 20_000_000;
  localparam int LAS_MEAS_MS = 600;
  localparam int TEC_MEAS_MS = 400;
  localparam int DISP_MS     = 3000;
  localparam int LAS_MEAS_CYC = (CLK_HZ / 1000) * LAS_MEAS_MS;
  localparam int TEC_MEAS_CYC = (CLK_HZ / 1000) * TEC_MEAS_MS;
  localparam int DISP_CYC     = (CLK_HZ / 1000) * DISP_MS;
  localparam int CW           = 26;

  typedef enum logic [0:0] {
    OPC_IDLE  = 1'b0,
    OPC_ARMED = 1'b1
  } soo_opc_t;

endpackage

// file: hdl/soo_status.sv
// status reporting, completion tracking, error queue and output-off logic
//
// Overview of operation
// R1: event bits stay set until their event register is read.
// R2: condition registers follow live state; reading them changes nothing.
// R3: each register masked by its enable, OR-reduced into one status byte bit.
// R4: operation-complete flag lives in bit 0 of standard event status.
// R5: OPC enabled, service enable bit 5, OPC command: request service on completion.
// R6: completion needs both updaters idle, no nonvolatile write, no display timer.
// R7: completion needs fresh laser measurement, refreshed about every 600 ms.
// R8: completion needs fresh temperature measurement, refreshed about every 400 ms.
// R9: completion needs each output off, or on and within tolerance.
// R10: calibration running holds the completion flag false.
// R11: commands run overlapped; completion flag set only when all criteria met.
// R12: wait command stalls later commands until no operation is pending.
// R13: settings-changing commands defer completion until nonvolatile writes drain.
// R14: new values act at parse; nonvolatile copy drains in background queue.
// R15: status byte bit 4 high while the response queue holds data.
// R16: status byte bit 7 high while the error queue holds an entry.
// R17: error list read returns queued codes, at most ten per response.
// R18: error shown on the display of the channel where it arose.
// R19: error message shown three seconds, then display reverts.
// R20: each new error replaces the displayed message at once.
// R21: output-off masks gate bits per channel, switch output off, not status.
// R22: output-off masks keep factory defaults regardless of status clear.
// R23: status byte read reports master summary in bit 6.
// R24: event set on detection; read clears atomically, new occurrence kept.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module soo_status
  import soo_pkg::*;
#(
  parameter int LAS_MEAS_CYCLES = LAS_MEAS_CYC,
  parameter int TEC_MEAS_CYCLES = TEC_MEAS_CYC,
  parameter int DISP_CYCLES     = DISP_CYC
) (
  input  wire logic          CLK,
  input  wire logic          RSTN,
  input  wire logic [AW-1:0] ADDR,
  input  wire logic [DW-1:0] WDATA,
  input  wire logic          WR,
  input  wire logic          RD,
  output logic      [DW-1:0] RDATA,
  input  wire logic [DW-1:0] LAS_COND,
  input  wire logic [DW-1:0] LAS_EVT,
  input  wire logic [DW-1:0] TEC_COND,
  input  wire logic [DW-1:0] TEC_EVT,
  input  wire logic [7:1]    ESR_EVT,
  input  wire logic          OUTQ_NOT_EMPTY,
  input  wire logic          CMD_PARSED,
  input  wire logic          OPC_CMD,
  input  wire logic          WAI_CMD,
  input  wire logic          LAS_UPD_BUSY,
  input  wire logic          TEC_UPD_BUSY,
  input  wire logic          NV_WRITE_BUSY,
  input  wire logic          CAL_RUN,
  input  wire logic          LAS_OUT_ON,
  input  wire logic          LAS_IN_TOL,
  input  wire logic          TEC_OUT_ON,
  input  wire logic          TEC_IN_TOL,
  input  wire logic          ERR_PUSH,
  input  wire logic [7:0]    ERR_CODE,
  input  wire logic          ERR_CHAN,
  output logic               SRQ,
  output logic               STALL,
  output logic               LAS_OUT_OFF,
  output logic               TEC_OUT_OFF,
  output logic               LAS_MEAS_REQ,
  output logic               TEC_MEAS_REQ,
  output logic               LAS_DISP_ACTIVE,
  output logic      [7:0]    LAS_DISP_CODE,
  output logic               TEC_DISP_ACTIVE,
  output logic      [7:0]    TEC_DISP_CODE
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                  sre;
    logic [7:0]                  esr;
    logic [7:0]                  ese;
    logic [DW-1:0]               las_evt;
    logic [DW-1:0]               las_en_c;
    logic [DW-1:0]               las_en_e;
    logic [DW-1:0]               tec_evt;
    logic [DW-1:0]               tec_en_c;
    logic [DW-1:0]               tec_en_e;
    logic [DW-1:0]               las_off;
    logic [DW-1:0]               tec_off;
    soo_opc_t                    opc;
    logic                        wai;
    logic                        las_fresh;
    logic                        tec_fresh;
    logic [CW-1:0]               las_tick;
    logic [CW-1:0]               tec_tick;
    logic [ERRQ_DEPTH-1:0][7:0]  q;
    logic [3:0]                  wp;
    logic [3:0]                  rp;
    logic [4:0]                  cnt;
    logic [3:0]                  resp;
    logic [7:0]                  las_code;
    logic [CW-1:0]               las_disp;
    logic [7:0]                  tec_code;
    logic [CW-1:0]               tec_disp;
    logic [DW-1:0]               rdata;
  } soo_state_t;

  soo_state_t st;
  soo_state_t next_st;

  function automatic logic rd_hit(input logic [AW-1:0] a);
    return RD && (ADDR == a);
  endfunction

  function automatic logic wr_hit(input logic [AW-1:0] a);
    return WR && (ADDR == a);
  endfunction

  // ----------------------------------------------------------------
  // summaries and completion
  // ----------------------------------------------------------------
  logic [7:0] stb_low;
  logic       master_summary_bit;
  logic [7:0] stb;
  logic       nop;
  logic       pop;
  logic       push;
  logic       opc_done;

  always_comb begin
    stb_low            = 8'h00;
    stb_low[STB_LAS_C] = |(LAS_COND & st.las_en_c);          // see R3
    stb_low[STB_LAS_E] = |(st.las_evt & st.las_en_e);        // see R3
    stb_low[STB_TEC_C] = |(TEC_COND & st.tec_en_c);          // see R3
    stb_low[STB_TEC_E] = |(st.tec_evt & st.tec_en_e);        // see R3
    stb_low[STB_OUTQ]  = OUTQ_NOT_EMPTY;                     // see R15
    stb_low[STB_ESR]   = |(st.esr & st.ese);                 // see R4
    stb_low[STB_ERRQ]  = (st.cnt != 5'h00);                  // see R16
    master_summary_bit                = |(stb_low & st.sre);
    stb                = stb_low;
    stb[STB_MSS]       = master_summary_bit;                                // see R23
  end

  // criteria for no operation pending; settings writes show as NV_WRITE_BUSY
  assign nop = !LAS_UPD_BUSY && !TEC_UPD_BUSY                // see R6
            && !NV_WRITE_BUSY                                // see R13
            && (st.las_disp == '0) && (st.tec_disp == '0)    // see R6
            && st.las_fresh                                  // see R7
            && st.tec_fresh                                  // see R8
            && (!LAS_OUT_ON || LAS_IN_TOL)                   // see R9
            && (!TEC_OUT_ON || TEC_IN_TOL)                   // see R9
            && !CAL_RUN;                                     // see R10

  assign opc_done = (st.opc == OPC_ARMED) && nop;            // see R11
  assign push     = ERR_PUSH && (st.cnt != 5'(ERRQ_DEPTH));
  assign pop      = rd_hit(A_ERR_DATA) && (st.cnt != 5'h00)
                 && (st.resp != 4'(ERR_RESP_MAX));           // see R17

  assign SRQ          = master_summary_bit;                                 // see R5
  assign STALL        = (st.wai || WAI_CMD) && !nop;         // see R12
  assign LAS_OUT_OFF  = |((LAS_COND | st.las_evt) & st.las_off);  // see R21
  assign TEC_OUT_OFF  = |((TEC_COND | st.tec_evt) & st.tec_off);  // see R21
  assign LAS_MEAS_REQ = (st.las_tick == '0);
  assign TEC_MEAS_REQ = (st.tec_tick == '0);
  assign LAS_DISP_ACTIVE = (st.las_disp != '0);
  assign TEC_DISP_ACTIVE = (st.tec_disp != '0);
  assign LAS_DISP_CODE   = st.las_code;
  assign TEC_DISP_CODE   = st.tec_code;
  assign RDATA           = st.rdata;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // set wins over read clear
    next_st.las_evt = (rd_hit(A_LAS_EVT) ? '0 : st.las_evt) | LAS_EVT;   // see R1 see R24
    next_st.tec_evt = (rd_hit(A_TEC_EVT) ? '0 : st.tec_evt) | TEC_EVT;   // see R1 see R24
    next_st.esr     = (rd_hit(A_ESR) ? 8'h00 : st.esr)
                    | {ESR_EVT, opc_done};                               // see R4
    if (wr_hit(A_SRE))    next_st.sre      = WDATA[7:0];                 // see R14
    if (wr_hit(A_ESE))    next_st.ese      = WDATA[7:0];
    if (wr_hit(A_LAS_EN_C)) next_st.las_en_c = WDATA;
    if (wr_hit(A_LAS_EN_E)) next_st.las_en_e = WDATA;
    if (wr_hit(A_TEC_EN_C)) next_st.tec_en_c = WDATA;
    if (wr_hit(A_TEC_EN_E)) next_st.tec_en_e = WDATA;
    if (wr_hit(A_LAS_OFF))  next_st.las_off  = WDATA;
    if (wr_hit(A_TEC_OFF))  next_st.tec_off  = WDATA;

    // completion tracking
    case (st.opc)
      OPC_IDLE:  next_st.opc = OPC_CMD ? OPC_ARMED : OPC_IDLE;
      OPC_ARMED: next_st.opc = (nop && !OPC_CMD) ? OPC_IDLE : OPC_ARMED;
      default:   next_st.opc = OPC_IDLE;
    endcase
    next_st.wai = (st.wai || WAI_CMD) && !nop;                           // see R12

    // periodic measurement refresh; a new command makes old data stale
    next_st.las_tick = LAS_MEAS_REQ ? CW'(LAS_MEAS_CYCLES - 1) : st.las_tick - 1'b1;
    next_st.tec_tick = TEC_MEAS_REQ ? CW'(TEC_MEAS_CYCLES - 1) : st.tec_tick - 1'b1;
    next_st.las_fresh = LAS_MEAS_REQ || (st.las_fresh && !CMD_PARSED);   // see R7
    next_st.tec_fresh = TEC_MEAS_REQ || (st.tec_fresh && !CMD_PARSED);   // see R8

    // error queue
    if (push) begin
      next_st.q[st.wp] = ERR_CODE;
      next_st.wp       = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp   = st.rp + 1'b1;
      next_st.resp = st.resp + 1'b1;                                     // see R17
    end
    if (wr_hit(A_ERR_START)) next_st.resp = 4'h0;
    next_st.cnt = st.cnt + {4'h0, push} - {4'h0, pop};

    // per-channel error display, newest message replaces at once
    if (ERR_PUSH && !ERR_CHAN) begin                                     // see R18 see R20
      next_st.las_code = ERR_CODE;
      next_st.las_disp = CW'(DISP_CYCLES);                               // see R19
    end else if (st.las_disp != '0) begin
      next_st.las_disp = st.las_disp - 1'b1;                             // see R19
    end
    if (ERR_PUSH && ERR_CHAN) begin                                      // see R18 see R20
      next_st.tec_code = ERR_CODE;
      next_st.tec_disp = CW'(DISP_CYCLES);
    end else if (st.tec_disp != '0) begin
      next_st.tec_disp = st.tec_disp - 1'b1;
    end

    // read data, valid the cycle after the strobe
    next_st.rdata = '0;
    if (RD) begin
      case (ADDR)
        A_STB:       next_st.rdata = {8'h00, stb};                       // see R23
        A_SRE:       next_st.rdata = {8'h00, st.sre};
        A_ESR:       next_st.rdata = {8'h00, st.esr};
        A_ESE:       next_st.rdata = {8'h00, st.ese};
        A_LAS_COND:  next_st.rdata = LAS_COND;                           // see R2
        A_LAS_EVT:   next_st.rdata = st.las_evt;
        A_LAS_EN_C:  next_st.rdata = st.las_en_c;
        A_LAS_EN_E:  next_st.rdata = st.las_en_e;
        A_TEC_COND:  next_st.rdata = TEC_COND;                           // see R2
        A_TEC_EVT:   next_st.rdata = st.tec_evt;
        A_TEC_EN_C:  next_st.rdata = st.tec_en_c;
        A_TEC_EN_E:  next_st.rdata = st.tec_en_e;
        A_LAS_OFF:   next_st.rdata = st.las_off;
        A_TEC_OFF:   next_st.rdata = st.tec_off;
        A_ERR_DATA:  next_st.rdata = pop ? {8'h00, st.q[st.rp]} : '0;    // see R17
        A_ERR_COUNT: next_st.rdata = {11'h000, st.cnt};
        default:     next_st.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st         <= '0;
      st.opc     <= OPC_IDLE;
      st.las_off <= LAS_OFF_DEFAULT;                                     // see R22
      st.tec_off <= TEC_OFF_DEFAULT;                                     // see R22
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  logic rd_las_evt;
  logic rd_las_cond;
  logic rd_stb;
  assign rd_las_evt  = rd_hit(A_LAS_EVT);
  assign rd_las_cond = rd_hit(A_LAS_COND);
  assign rd_stb      = rd_hit(A_STB);

  property p_evt_hold;
    !rd_las_evt |=> ((st.las_evt & $past(st.las_evt)) == $past(st.las_evt));
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event bit lost"); // see R1

  property p_evt_clear;
    rd_las_evt |=> (st.las_evt == $past(LAS_EVT));
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("bad event clear"); // see R24

  property p_cond_read;
    rd_las_cond |=> (RDATA == $past(LAS_COND));
  endproperty
  a_cond_read: assert property (p_cond_read) else $error("cond read wrong"); // see R2

  property p_summary;
    rd_stb |=> (RDATA[STB_LAS_C] == $past(|(LAS_COND & st.las_en_c)));
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong"); // see R3

  property p_opc_bit;
    (st.opc == OPC_ARMED && nop) |=> st.esr[ESR_OPC];
  endproperty
  a_opc_bit: assert property (p_opc_bit) else $error("opc bit not set"); // see R4

  property p_srq;
    (st.esr[ESR_OPC] && st.ese[ESR_OPC] && st.sre[STB_ESR]) |-> SRQ;
  endproperty
  a_srq: assert property (p_srq) else $error("no service request"); // see R5

  property p_cal;
    (CAL_RUN && !st.esr[ESR_OPC]) |=> !st.esr[ESR_OPC];
  endproperty
  a_cal: assert property (p_cal) else $error("opc set in calibration"); // see R10

  property p_busy;
    (LAS_UPD_BUSY || NV_WRITE_BUSY) |-> !opc_done;
  endproperty
  a_busy: assert property (p_busy) else $error("opc while busy"); // see R6

  property p_stall;
    (WAI_CMD && !nop) |-> STALL ##1 (STALL || nop);
  endproperty
  a_stall: assert property (p_stall) else $error("wait not stalling"); // see R12

  property p_stb47;
    rd_stb |=> (RDATA[STB_OUTQ] == $past(OUTQ_NOT_EMPTY))
           && (RDATA[STB_ERRQ] == $past(st.cnt != 5'h00));
  endproperty
  a_stb47: assert property (p_stb47) else $error("queue bits wrong"); // see R15 see R16

  property p_resp;
    st.resp <= 4'(ERR_RESP_MAX);
  endproperty
  a_resp: assert property (p_resp) else $error("too many errors read"); // see R17

  property p_disp;
    (ERR_PUSH && !ERR_CHAN) |=> LAS_DISP_ACTIVE && (LAS_DISP_CODE == $past(ERR_CODE));
  endproperty
  a_disp: assert property (p_disp) else $error("error not displayed"); // see R18 see R20

  property p_mss;
    rd_stb |=> (RDATA[STB_MSS] == $past(master_summary_bit));
  endproperty
  a_mss: assert property (p_mss) else $error("bit 6 not summary"); // see R23

  property p_tec_disp;
    (ERR_PUSH && ERR_CHAN) |=> TEC_DISP_ACTIVE && (TEC_DISP_CODE == $past(ERR_CODE));
  endproperty
  a_tec_disp: assert property (p_tec_disp) else $error("temp display wrong"); // see R18 see R20

  property p_off_evt;
    |(st.las_evt & st.las_off) |-> LAS_OUT_OFF;
  endproperty
  a_off_evt: assert property (p_off_evt) else $error("event did not switch off"); // see R21

  property p_errq_cap;
    st.cnt <= 5'(ERRQ_DEPTH);
  endproperty
  a_errq_cap: assert property (p_errq_cap) else $error("error queue overrun"); // see R17

  c_opc_srq:   cover property (opc_done ##1 SRQ);
  c_wai_end:   cover property (STALL ##1 !STALL);
  c_err_read:  cover property (pop ##1 (RDATA != '0));
  c_las_off:   cover property (!LAS_OUT_OFF ##1 LAS_OUT_OFF);
  c_tec_disp:  cover property (ERR_PUSH && ERR_CHAN ##1 TEC_DISP_ACTIVE);

endmodule
`default_nettype wire
